/* File: common/tcs_pkg.sv */
`default_nettype none
package tcs_pkg;
   localparam logic [7:0] ADDR_CLK_CTRL   = 8'h8e;
   localparam logic [7:0] ADDR_CLK_CTRL2  = 8'he4;
   localparam logic [7:0] RESET_CLK_CTRL  = 8'h00;
   localparam logic [7:0] RESET_CLK_CTRL2 = 8'h00;
   localparam logic [7:0] CTRL2_RW_MASK   = 8'h0f;
   localparam int BIT_TIMER0_SEL = 2;
   localparam int BIT_TIMER1_SEL = 3;
   localparam int BIT_T2_LO = 4;
   localparam int BIT_T2_HI = 5;
   localparam int BIT_T3_LO = 6;
   localparam int BIT_T3_HI = 7;
   localparam int BIT_T4_LO = 0;
   localparam int BIT_T4_HI = 1;
   localparam int BIT_T5_LO = 2;
   localparam int BIT_T5_HI = 3;
   localparam logic [1:0] PRESCALE_DIV12 = 2'h0;
   localparam logic [1:0] PRESCALE_DIV4  = 2'h1;
   localparam logic [1:0] PRESCALE_DIV48 = 2'h2;
   localparam logic [1:0] PRESCALE_EXT8  = 2'h3;
   localparam logic [5:0] DIV12_LAST = 6'h0b;
   localparam logic [5:0] DIV4_LAST  = 6'h03;
   localparam logic [5:0] DIV48_LAST = 6'h2f;
   localparam logic [2:0] EXT8_LAST  = 3'h7;
   localparam int NUM_ALT = 4;

   // Per-timer clock enables; each field is a one-cycle pulse per tick.
   typedef struct packed {
      logic timer0;
      logic timer1;
      logic [3:0] altLow;  // Timers 2..5 low byte or whole timer.
      logic [3:0] altHigh; // Timers 2..5 high byte in split mode.
   } tcs_ticks_s;

   typedef struct packed {
      logic [7:0] en;
      logic [7:0] addr;
      logic [7:0] data;
   } tcs_wr_s;
endpackage
`default_nettype wire

/* File: verilog/tcs_edge_counter.sv */
`timescale 1ns/10ps
`default_nettype none
module tcs_edge_counter (
   input  wire logic clk,      // System clock.
   input  wire logic resetn,   // Synchronous reset, active low.
   input  wire logic eventIn,  // Event pin, synchronous to clk.
   output logic      fallTick  // One-cycle pulse per falling edge.
);
   typedef struct packed {
      logic prev;
      logic tick;
   } tcs_edge_s;

   tcs_edge_s state_r;
   tcs_edge_s state_nxt;

   // Sampling every cycle resolves edges up to a quarter of clk when levels hold two cycles.
   always_comb begin
      state_nxt      = state_r;
      state_nxt.prev = eventIn;
      state_nxt.tick = state_r.prev & ~eventIn;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_r <= '{prev: 1'b1, tick: 1'b0};
      end else begin
         state_r <= state_nxt;
      end
   end

   assign fallTick = state_r.tick;
endmodule // tcs_edge_counter
`default_nettype wire

/* File: verilog/tcs_clock_select.sv */
// Behaviour
// - The shared prescaled tick is clk/12, clk/4, clk/48 or synced external clock /8 by the two-bit prescale field.
// - Timer 0 uses the prescaled tick when its select bit 2 is 0 and clk when 1, ignored in counter mode.
// - Timer 1 uses the prescaled tick when its select bit 3 is 0 and clk when 1, ignored in counter mode.
// - In counter mode Timer 0 or 1 advances once per falling edge on its event pin.
// - Events up to a quarter of the clock rate are counted, periodic or not.
// - Timers 2 to 5 can run from clk, clk/12 or external clock /8.
// - Bit 4 picks clk for Timer 2 low byte else its alternate clock, bit 5 likewise for the split high byte.
// - Bit 6 picks clk for Timer 3 low byte else its alternate clock, bit 7 likewise for the split high byte.
// - Second register bit 0 picks clk for Timer 4 low byte, bit 1 for the split high byte.
// - Second register bit 2 picks clk for Timer 5 low byte, bit 3 for the split high byte.
// - The upper four bits of the second register read zero and ignore writes.
// - A set counter-mode bit counts event edges, a clear one uses the selected clock.
`timescale 1ns/10ps
`default_nettype none
module tcs_clock_select (
   input  wire logic                  clk,                   // System clock, 100 MHz.
   input  wire logic                  resetn,                // Synchronous reset, active low.
   input  wire logic                  regWrite,              // Register write strobe.
   input  wire logic [7:0]            regAddr,               // Register address.
   input  wire logic [7:0]            regWdata,              // Write data.
   output logic      [7:0]            regRdata,              // Read data for regAddr.
   input  wire logic                  extClock,              // External oscillator, synchronous.
   input  wire logic                  timer0CounterMode,     // Timer 0 counts pin edges.
   input  wire logic                  timer1CounterMode,     // Timer 1 counts pin edges.
   input  wire logic                  timer0EventInput,      // Timer 0 event pin.
   input  wire logic                  timer1EventInput,      // Timer 1 event pin.
   input  wire logic [3:0]            timerAltClockSelect,   // Timers 2..5: 1 = ext/8, 0 = clk/12.
   input  wire logic [3:0]            timerSplitMode,        // Timers 2..5 split 8-bit mode.
   output tcs_pkg::tcs_ticks_s        ticks                  // Per-timer count enables.
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] ctrl2;
      logic [5:0] preCnt;
      logic [5:0] div12Cnt;
      logic [2:0] extCnt;
      logic       extPrev;
      logic       extTick;
      logic       preTick;
      logic       div12Tick;
      logic [7:0] rdata;
      tcs_pkg::tcs_ticks_s ticks;
   } tcs_state_s;

   tcs_state_s state_r;
   tcs_state_s state_nxt;
   logic       timer0Fall;
   logic       timer1Fall;

   function automatic logic [5:0] prescaleLast(input logic [1:0] sel);
      case (sel)
         tcs_pkg::PRESCALE_DIV4:  prescaleLast = tcs_pkg::DIV4_LAST;
         tcs_pkg::PRESCALE_DIV48: prescaleLast = tcs_pkg::DIV48_LAST;
         default:                 prescaleLast = tcs_pkg::DIV12_LAST;
      endcase
   endfunction

   // Selects clk (every cycle) when the bit is set, else the timer's alternate tick.
   function automatic logic pickTick(input logic sysSel, input logic altTick);
      pickTick = sysSel | altTick;
   endfunction

   tcs_edge_counter uTimer0Edge (
      .clk      (clk),
      .resetn   (resetn),
      .eventIn  (timer0EventInput),
      .fallTick (timer0Fall)
   );

   tcs_edge_counter uTimer1Edge (
      .clk      (clk),
      .resetn   (resetn),
      .eventIn  (timer1EventInput),
      .fallTick (timer1Fall)
   );

   always_comb begin
      logic [1:0] prescaleSel;
      logic       altTick;
      logic       splitHi;
      logic       loSel;
      logic       hiSel;
      prescaleSel = state_r.ctrl[1:0];
      altTick   = 1'b0;
      splitHi   = 1'b0;
      loSel     = 1'b0;
      hiSel     = 1'b0;
      state_nxt = state_r;

      if (regWrite && regAddr == tcs_pkg::ADDR_CLK_CTRL) begin
         state_nxt.ctrl = regWdata;
      end
      if (regWrite && regAddr == tcs_pkg::ADDR_CLK_CTRL2) begin
         state_nxt.ctrl2 = regWdata & tcs_pkg::CTRL2_RW_MASK;
      end

      // External clock is taken as already synchronous; rising edges feed the /8.
      state_nxt.extPrev = extClock;
      state_nxt.extTick = 1'b0;
      if (extClock && !state_r.extPrev) begin
         state_nxt.extCnt = state_r.extCnt + 3'h1;
         state_nxt.extTick = (state_r.extCnt == tcs_pkg::EXT8_LAST);
      end

      // Fixed clk/12 for the alternate clocks of Timers 2..5.
      state_nxt.div12Tick = 1'b0;
      if (state_r.div12Cnt >= tcs_pkg::DIV12_LAST) begin
         state_nxt.div12Cnt  = 6'h00;
         state_nxt.div12Tick = 1'b1;
      end else begin
         state_nxt.div12Cnt = state_r.div12Cnt + 6'h01;
      end

      // A shrinking divide wraps at once via >=, so a ratio change never runs a long lap.
      state_nxt.preTick = 1'b0;
      if (prescaleSel == tcs_pkg::PRESCALE_EXT8) begin
         state_nxt.preCnt  = 6'h00;
         state_nxt.preTick = state_r.extTick;
      end else if (state_r.preCnt >= prescaleLast(prescaleSel)) begin
         state_nxt.preCnt  = 6'h00;
         state_nxt.preTick = 1'b1;
      end else begin
         state_nxt.preCnt = state_r.preCnt + 6'h01;
      end

      state_nxt.ticks.timer0 = timer0CounterMode ? timer0Fall
                             : pickTick(state_r.ctrl[tcs_pkg::BIT_TIMER0_SEL], state_r.preTick);
      state_nxt.ticks.timer1 = timer1CounterMode ? timer1Fall
                             : pickTick(state_r.ctrl[tcs_pkg::BIT_TIMER1_SEL], state_r.preTick);

      for (int i = 0; i < tcs_pkg::NUM_ALT; i++) begin
         altTick = timerAltClockSelect[i] ? state_r.extTick : state_r.div12Tick;
         case (i)
            0: begin
               loSel = state_r.ctrl[tcs_pkg::BIT_T2_LO];
               hiSel = state_r.ctrl[tcs_pkg::BIT_T2_HI];
            end
            1: begin
               loSel = state_r.ctrl[tcs_pkg::BIT_T3_LO];
               hiSel = state_r.ctrl[tcs_pkg::BIT_T3_HI];
            end
            2: begin
               loSel = state_r.ctrl2[tcs_pkg::BIT_T4_LO];
               hiSel = state_r.ctrl2[tcs_pkg::BIT_T4_HI];
            end
            default: begin
               loSel = state_r.ctrl2[tcs_pkg::BIT_T5_LO];
               hiSel = state_r.ctrl2[tcs_pkg::BIT_T5_HI];
            end
         endcase
         // Outside split mode the high select has no effect; the high byte follows the low one.
         splitHi = timerSplitMode[i] ? hiSel : loSel;
         state_nxt.ticks.altLow[i]  = pickTick(loSel, altTick);
         state_nxt.ticks.altHigh[i] = pickTick(splitHi, altTick);
      end

      case (regAddr)
         tcs_pkg::ADDR_CLK_CTRL:  state_nxt.rdata = state_nxt.ctrl;
         tcs_pkg::ADDR_CLK_CTRL2: state_nxt.rdata = state_nxt.ctrl2;
         default:                 state_nxt.rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_r       <= '0;
         state_r.ctrl  <= tcs_pkg::RESET_CLK_CTRL;
         state_r.ctrl2 <= tcs_pkg::RESET_CLK_CTRL2;
         state_r.extPrev <= 1'b1;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign regRdata = state_r.rdata;
   assign ticks    = state_r.ticks;
endmodule // tcs_clock_select
`default_nettype wire

/* File: tb/tcs_event_src.sv */
`timescale 1ns/10ps
`default_nettype none
module tcs_event_src (
   input  wire logic       clk,    // System clock.
   input  wire logic [3:0] hold,   // Cycles per level, zero idles high.
   output logic            ev0,    // Timer 0 event pin.
   output logic            ev1,    // Timer 1 event pin.
   output logic            extClk  // External oscillator.
);
   logic [3:0] cnt = 4'h0;
   initial {ev0, ev1, extClk} = 3'h6;
   // The oscillator runs free at half the system rate, so ext/8 ticks every 16 cycles.
   always @(posedge clk) begin
      #1 extClk <= ~extClk;
      cnt <= cnt + 4'h1;
      if (hold == 4'h0) begin
         {ev0, ev1} <= 2'h3;
      end else if (cnt + 4'h1 >= hold) begin
         cnt <= 4'h0;
         {ev0, ev1} <= {~ev0, ev0};
      end
   end
endmodule // tcs_event_src
`default_nettype wire

/* File: tb/tcs_clock_select_props.sv */
`timescale 1ns/10ps
`default_nettype none
module tcs_clock_select_props (
   input wire logic                clk,               // Clock.
   input wire logic                resetn,            // Reset.
   input wire logic                regWrite,          // Write.
   input wire logic [7:0]          regAddr,           // Address.
   input wire logic [7:0]          regWdata,          // Data.
   input wire logic [7:0]          regRdata,          // Read data.
   input wire logic                timer0CounterMode, // Mode.
   input wire logic                timer0EventInput,  // Pin.
   input wire logic [3:0]          timerSplitMode,    // Split.
   input wire tcs_pkg::tcs_ticks_s ticks              // Enables.
);
   logic [7:0] c1_r;
   logic [7:0] c2_r;
   wire        cfg0 = c1_r[3:0] == 4'h0 && !timer0CounterMode;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         c1_r <= 8'h00;
         c2_r <= 8'h00;
      end else if (regWrite && regAddr == 8'h8e) begin
         c1_r <= regWdata;
      end else if (regWrite && regAddr == 8'he4) begin
         c2_r <= regWdata & 8'h0f;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   rd_first_a: assert property ($past(regAddr) == 8'h8e |-> regRdata == c1_r)
      else $error("first register read wrong");
   rd_second_a: assert property ($past(regAddr) == 8'he4 |-> regRdata == c2_r)
      else $error("second register read wrong");
   timer0_sys_a: assert property ((c1_r[2] && !timer0CounterMode) [*3] |-> ticks.timer0)
      else $error("timer 0 system clock missing");
   timer0_count_a: assert property (timer0CounterMode [*2] ##0 $fell(timer0EventInput) |-> ##[1:3] ticks.timer0)
      else $error("event not counted");
   div12_gap_a: assert property (cfg0 [*3] ##0 ticks.timer0 |=> (!ticks.timer0 || !cfg0) [*8])
      else $error("divide by 12 too fast");
   t2_sys_a: assert property (c1_r[4] [*3] |-> ticks.altLow[0])
      else $error("timer 2 system clock missing");
   t5_high_a: assert property ((c2_r[3] && timerSplitMode[3]) [*3] |-> ticks.altHigh[3])
      else $error("timer 5 high byte clock missing");
   no_split_a: assert property ((!timerSplitMode[0]) [*3] |-> ticks.altHigh[0] == ticks.altLow[0])
      else $error("high byte differs outside split mode");
   cover property (ticks.timer0 && timer0CounterMode);
   cover property (c1_r[1:0] == 2'h3 && ticks.timer0);
   cover property (ticks.altHigh == 4'hf && ticks.altLow != 4'hf);
endmodule // tcs_clock_select_props
bind tcs_clock_select tcs_clock_select_props u_props (.clk, .resetn, .regWrite, .regAddr, .regWdata, .regRdata,
   .timer0CounterMode, .timer0EventInput, .timerSplitMode, .ticks);
`default_nettype wire

/* File: tb/test_timer_clock_source_select.sv */
`timescale 1ns/10ps
`default_nettype none
module test_timer_clock_source_select;
   logic                clk = 1'b0;
   logic                resetn = 1'b0;
   logic                regWrite = 1'b0;
   logic [7:0]          regAddr = 8'h00;
   logic [7:0]          regWdata = 8'h00;
   logic [7:0]          regRdata;
   logic                extClock;
   logic                ev0;
   logic                ev1;
   logic [1:0]          mode = 2'h0;
   logic [3:0]          altSel = 4'h0;
   logic [3:0]          split = 4'h0;
   logic [3:0]          hold = 4'h0;
   tcs_pkg::tcs_ticks_s ticks;
   int                  failures = 0;
   int                  cmp_count = 0;
   int                  n;
   int                  divs [4] = '{12, 4, 48, 16};
   logic [23:0]         rows [5] = '{24'h8effff, 24'he4ff0f, 24'he4a505, 24'h55ff00, 24'h8e1313};
   tcs_clock_select uut (.clk(clk), .resetn(resetn), .regWrite(regWrite), .regAddr(regAddr),
      .regWdata(regWdata), .regRdata(regRdata), .extClock(extClock), .timer0CounterMode(mode[0]),
      .timer1CounterMode(mode[1]), .timer0EventInput(ev0), .timer1EventInput(ev1),
      .timerAltClockSelect(altSel), .timerSplitMode(split), .ticks(ticks));
   tcs_event_src src (.clk(clk), .hold(hold), .ev0(ev0), .ev1(ev1), .extClk(extClock));
   task automatic finish_test();
      $display("failures=%0d cmp_count=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 {regWrite, regAddr, regWdata} = {1'b1, a, d};
      @(posedge clk);
      #1 regWrite = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      #1 regAddr = a;
      @(posedge clk);
      #1 chk({2'h0, regRdata}, {2'h0, e});
   endtask
   // The first tick after a change may still come from the old setting, so the gap between the second and third ticks is timed.
   task automatic gap(input int b, input int e);
      repeat (3) begin
         n = 0;
         do begin
            @(posedge clk);
            #1 n++;
         end while (ticks[b] !== 1'b1 && n < 300);
      end
      if (n >= 300) begin
         failures++;
         finish_test();
      end else begin
         chk(10'(n), 10'(e));
      end
   endtask
   initial forever #5 clk = ~clk;
   initial begin
      repeat (6) @(posedge clk);
      #1 chk(ticks, 10'h000);
      resetn = 1'b1;
      rd(8'h8e, 8'h00);
      rd(8'he4, 8'h00);
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0]);
      end
      for (int k = 0; k < 4; k++) begin
         wr(8'h8e, 8'(k));
         gap(9, divs[k]);
         gap(8, divs[k]);
      end
      wr(8'h8e, 8'h00);
      wr(8'he4, 8'h00);
      for (int k = 0; k < 2; k++) begin
         altSel = 4'(k * 15);
         gap(4, divs[k * 3]);
         gap(7, divs[k * 3]);
      end
      altSel = 4'h0;
      split = 4'hf;
      wr(8'h8e, 8'hfc);
      wr(8'he4, 8'hff);
      repeat (3) @(posedge clk);
      #1 chk(ticks, 10'h3ff);
      wr(8'h8e, 8'ha0);
      wr(8'he4, 8'h0a);
      repeat (3) @(posedge clk);
      #1 chk({6'h00, ticks.altHigh}, 10'h00f);
      split = 4'h0;
      gap(0, 12);
      wr(8'h8e, 8'hfc);
      mode = 2'h3;
      for (int k = 2; k < 4; k++) begin
         hold = 4'(k);
         gap(9, 2 * k);
         gap(8, 2 * k);
      end
      resetn = 1'b0;
      @(posedge clk);
      #1 chk(ticks, 10'h000);
      resetn = 1'b1;
      rd(8'h8e, 8'h00);
      rd(8'he4, 8'h00);
      finish_test();
   end
endmodule // test_timer_clock_source_select
`default_nettype wire
